// ---- logic/acr_device.sv ----
/*
 Device end: the 8-bit feature configuration register and the decoder
 of the 16-bit register access instruction on the serial link.
 Assumes link pins and the overvoltage level are asynchronous to
 refClk and that serial clock half periods span several refClk cycles.
*/
`default_nettype none
module acr_device
   import acr_pkg::*;
(
   input wire logic refClk,
   input wire logic reset,
   acr_link_if.dev link,
   input wire logic overvoltageIn,
   output logic statusBitsEn,
   output logic spanCompressEn,
   output logic highZEn,
   output logic turboEn,
   output logic overvoltageIndicatorN
);
   import acr_pkg::*;

   // ==========================================
   // Input synchronisation
   logic [3:0] syncBus;      // Synchronised pins
   logic cnvS;               // Frame line, synchronised
   logic sclkS;              // Serial clock, synchronised
   logic sdiS;               // Serial data in, synchronised
   logic ovS;                // Overvoltage level, synchronised
   logic sclkPrev_ff;        // Serial clock one cycle back
   logic cnvPrev_ff;         // Frame line one cycle back
   logic sclkRise;           // Rising serial clock seen
   logic sclkFall;           // Falling serial clock seen
   logic frameOn;            // Frame active

   // Pins start idle: data high, frame high, clock low, no overvoltage
   acr_sync #(.W(4), .INIT(4'hC)) uSync (
      .refClk(refClk),
      .reset(reset),
      .asyncIn({link.serialIn, link.conversionStart, link.serialClk, overvoltageIn}),
      .syncOut(syncBus)
   );
   assign sdiS = syncBus[3];
   assign cnvS = syncBus[2];
   assign sclkS = syncBus[1];
   assign ovS = syncBus[0];

   // Edge history of clock and frame line
   always_ff @(posedge refClk) begin
      if (reset) begin
         sclkPrev_ff <= 1'b0;
         cnvPrev_ff <= 1'b1;
      end else begin
         sclkPrev_ff <= sclkS;
         cnvPrev_ff <= cnvS;
      end
   end
   assign frameOn = !cnvS;
   assign sclkRise = frameOn && sclkS && !sclkPrev_ff;
   assign sclkFall = frameOn && !sclkS && sclkPrev_ff;

   // ==========================================
   // Frame decoding
   logic [4:0] bitCnt_ff;    // Bits taken this frame
   logic [7:0] rxShift_ff;   // Incoming bits
   logic [7:0] txShift_ff;   // Outgoing register image
   logic isRead_ff;          // Valid read command decoded
   logic isWrite_ff;         // Valid write command decoded
   logic [7:0] cmdByte;      // Command byte as it completes
   logic cmdOk;              // Command byte accepted
   logic [7:1] cfgRw_ff;     // Enable bits and reserved bits
   logic ovN_ff;             // Sticky overvoltage indicator, active low
   logic [7:0] cfgNow;       // Configuration register as held
   logic [7:0] cfgView;      // Register as read back

   assign cmdByte = {rxShift_ff[6:0], sdiS};
   assign cmdOk = !cmdByte[CMD_START_BIT]
                  && (cmdByte[5:0] == CMD_PATTERN);
   assign cfgNow = {cfgRw_ff, ovN_ff};
   assign cfgView = cfgNow & (CFG_WR_MASK | CFG_RESET);

   // Bit counter, restarted by each frame, saturates after 16
   always_ff @(posedge refClk) begin
      if (reset || !frameOn) begin
         bitCnt_ff <= '0;
      end else if (sclkRise && bitCnt_ff != CNT_DONE) begin
         bitCnt_ff <= bitCnt_ff + 5'h01;
      end
   end

   // Serial input shifter, sampled on rising clock
   always_ff @(posedge refClk) begin
      if (reset) begin
         rxShift_ff <= '0;
      end else if (sclkRise) begin
         rxShift_ff <= cmdByte;
      end
   end

   // Command decode after the eighth bit
   always_ff @(posedge refClk) begin
      if (reset || !frameOn) begin
         isRead_ff <= 1'b0;
         isWrite_ff <= 1'b0;
      end else if (sclkRise && bitCnt_ff == CNT_CMD_LAST) begin
         // Mismatched pattern: rest of the frame ignored
         isRead_ff <= cmdOk && cmdByte[CMD_RD_BIT];
         isWrite_ff <= cmdOk && !cmdByte[CMD_RD_BIT];
      end
   end

   // ==========================================
   // Configuration register
   // Write lands only once the whole data byte is in
   always_ff @(posedge refClk) begin
      if (reset) begin
         cfgRw_ff <= CFG_RESET[7:1];
      end else if (sclkRise && isWrite_ff && bitCnt_ff == CNT_LAST) begin
         cfgRw_ff <= (cmdByte[7:1] & CFG_WR_MASK[7:1])
                     | (cfgRw_ff & ~CFG_WR_MASK[7:1]);
      end
   end

   // Sticky active-low overvoltage indicator; a new event beats the clear
   always_ff @(posedge refClk) begin
      if (reset) begin
         ovN_ff <= CFG_RESET[BIT_OV_N];
      end else if (ovS) begin
         ovN_ff <= 1'b0;
      end else if (sclkRise && isRead_ff && bitCnt_ff == CNT_LAST) begin
         ovN_ff <= 1'b1;
      end
   end

   // ==========================================
   // Serial output
   // Image taken at decode, shifted out MSB first on falling clock
   always_ff @(posedge refClk) begin
      if (reset) begin
         txShift_ff <= '0;
      end else if (sclkRise && bitCnt_ff == CNT_CMD_LAST) begin
         txShift_ff <= cfgView;
      end else if (sclkFall && isRead_ff && bitCnt_ff < CNT_DONE) begin
         txShift_ff <= {txShift_ff[6:0], 1'b0};
      end
   end

   // Output drive, floated one cycle after the synchronised frame line goes high
   always_ff @(posedge refClk) begin
      if (reset || !frameOn) begin
         link.serialOut <= 1'b0;
         link.serialOutOeN <= 1'b1;
      end else if (sclkFall && isRead_ff && bitCnt_ff < CNT_DONE) begin
         link.serialOut <= txShift_ff[7];
         link.serialOutOeN <= 1'b0;
      end
   end

   // ==========================================
   // Feature outputs, registered copies of the enables and the overvoltage flag
   always_ff @(posedge refClk) begin
      if (reset) begin
         statusBitsEn <= CFG_RESET[BIT_STATUS_EN];
         spanCompressEn <= CFG_RESET[BIT_SPAN_EN];
         highZEn <= CFG_RESET[BIT_HIGHZ_EN];
         turboEn <= CFG_RESET[BIT_TURBO_EN];
         overvoltageIndicatorN <= CFG_RESET[BIT_OV_N];
      end else begin
         statusBitsEn <= cfgNow[BIT_STATUS_EN];
         spanCompressEn <= cfgNow[BIT_SPAN_EN];
         highZEn <= cfgNow[BIT_HIGHZ_EN];
         turboEn <= cfgNow[BIT_TURBO_EN];
         overvoltageIndicatorN <= cfgNow[BIT_OV_N];
      end
   end
endmodule : acr_device
`default_nettype wire

// ---- logic/acr_pkg.sv ----
/*
 Shared constants for the configuration register access link: register
 layout, reset value, command byte pattern, frame length and host map.
 Assumes both ends and the host's APB slave import it.
*/
`default_nettype none
package acr_pkg;
   // ==========================================
   // Configuration register layout
   localparam int CFG_W = 8;               // Register width
   localparam int BIT_STATUS_EN = 4;       // Status bits enable
   localparam int BIT_SPAN_EN = 3;         // Span compression enable
   localparam int BIT_HIGHZ_EN = 2;        // High-Z mode enable
   localparam int BIT_TURBO_EN = 1;        // Turbo mode enable
   localparam int BIT_OV_N = 0;            // Overvoltage indicator, active low
   localparam logic [7:0] CFG_RESET = 8'h01;     // Reset value
   localparam logic [7:0] CFG_WR_MASK = 8'h1E;   // Writable bits 4..1
   // ==========================================
   // Register access command byte
   localparam int CMD_START_BIT = 7;       // Access start, must be 0
   localparam int CMD_RD_BIT = 6;          // 1 read, 0 write
   localparam logic [5:0] CMD_PATTERN = 6'h14;   // Fixed bits 5..0
   localparam int CMD_BITS = 8;            // Command length
   localparam int FRAME_BITS = 16;         // Whole instruction length
   localparam logic [4:0] CNT_CMD_LAST = 5'h07;  // Index of last command bit
   localparam logic [4:0] CNT_LAST = 5'h0F;      // Index of last frame bit
   localparam logic [4:0] CNT_DONE = 5'h10;      // Counter saturation
   // ==========================================
   // Host register map over APB
   localparam logic [31:0] HOST_CMD_ADDR = 32'h0000_0000;   // Order register
   localparam logic [31:0] HOST_STAT_ADDR = 32'h0000_0004;  // Status register
   localparam int HCMD_RD_BIT = 8;         // Order: 1 read, 0 write
   localparam int HSTAT_BUSY_BIT = 0;      // Status: transfer running
   localparam int HSTAT_DONE_BIT = 1;      // Status: transfer finished
   localparam int HSTAT_DATA_LSB = 8;      // Status: read data position
   localparam logic [3:0] SCLK_HALF_DEF = 4'h8;  // Ref cycles per half period
endpackage : acr_pkg
`default_nettype wire

// ---- logic/acr_link_if.sv ----
/*
 Serial link between the host and the device: frame line, serial
 clock, serial data in and a tristate-able serial data out.
 Assumes the bench resolves the data-out wire from its enable.
*/
`default_nettype none
interface acr_link_if;
   logic conversionStart;  // Frame line, low frames an access
   logic serialClk;        // Serial clock, idle low
   logic serialIn;         // Host to device data
   logic serialOut;        // Device to host data
   logic serialOutOeN;     // Low while the device drives serialOut
   // Device end
   modport dev (input conversionStart, input serialClk, input serialIn,
                output serialOut, output serialOutOeN);
   // Host end
   modport host (output conversionStart, output serialClk, output serialIn,
                 input serialOut, input serialOutOeN);
endinterface : acr_link_if
`default_nettype wire

// ---- logic/acr_sync.sv ----
/*
 Two flip-flop synchroniser for a bundle of independent levels.
 Assumes each bit is a level; the first stage feeds only the second.
*/
`default_nettype none
module acr_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] INIT = '0
) (
   input wire logic refClk,
   input wire logic reset,
   input wire logic [W-1:0] asyncIn,
   output logic [W-1:0] syncOut
);
   logic [W-1:0] meta_ff;  // First stage
   logic [W-1:0] sync_ff;  // Second stage

   // ==========================================
   // Two stage capture
   always_ff @(posedge refClk) begin
      if (reset) begin
         meta_ff <= INIT;
         sync_ff <= INIT;
      end else begin
         meta_ff <= asyncIn;
         sync_ff <= meta_ff;
      end
   end
   assign syncOut = sync_ff;
endmodule : acr_sync
`default_nettype wire

// ---- logic/acr_host.sv ----
/*
 Host end: takes register read or write orders over APB and runs one
 16-bit instruction per order on the serial link, serial clock derived
 from refClk by a divider.
 Assumes a single APB master; serialOut is asynchronous to refClk.
*/
`default_nettype none
module acr_host
   import acr_pkg::*;
#(
   parameter logic [3:0] SCLK_HALF = SCLK_HALF_DEF  // Half period, >= 6
) (
   input wire logic refClk,
   input wire logic reset,
   acr_link_if.host link,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr
);
   import acr_pkg::*;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,   // Frame line high
      ST_LEAD = 2'b01,   // Frame low, first bit set up
      ST_SHIFT = 2'b10,  // Clocking 16 bits
      ST_TAIL = 2'b11    // Hold after last falling edge
   } acr_hstate_e;

   acr_hstate_e state_ff;    // Link sequencer state
   logic [3:0] divCnt_ff;    // Half period divider
   logic halfTick;           // One-cycle half period enable
   logic [4:0] bitCnt_ff;    // Rising edges issued
   logic [15:0] txShift_ff;  // Instruction being sent
   logic [7:0] rxData_ff;    // Bits sampled back
   logic busy_ff;            // Transfer running
   logic done_ff;            // Transfer finished
   logic sdoS;               // Device data, synchronised
   logic apbAccess;          // Access phase
   logic startReq;           // Accepted order

   acr_sync #(.W(1), .INIT(1'b0)) uSync (
      .refClk(refClk),
      .reset(reset),
      .asyncIn(link.serialOut),
      .syncOut(sdoS)
   );

   // ==========================================
   // APB slave, zero wait states
   assign apbAccess = psel && penable;
   assign startReq = apbAccess && pwrite && paddr == HOST_CMD_ADDR && !busy_ff;

   // Read data and error answer, registered at the setup cycle
   always_ff @(posedge refClk) begin
      if (reset) begin
         prdata <= '0;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= psel && !penable;
         pslverr <= psel && !penable && paddr != HOST_CMD_ADDR && paddr != HOST_STAT_ADDR;
         prdata <= '0;
         if (psel && !penable && paddr == HOST_STAT_ADDR) begin
            prdata[HSTAT_BUSY_BIT] <= busy_ff;
            prdata[HSTAT_DONE_BIT] <= done_ff;
            prdata[HSTAT_DATA_LSB +: 8] <= rxData_ff;
         end
      end
   end

   // ==========================================
   // Serial clock divider; SCLK_HALF sets the rate for the application
   always_ff @(posedge refClk) begin
      if (reset || state_ff == ST_IDLE || divCnt_ff == SCLK_HALF - 4'h1) begin
         divCnt_ff <= '0;
      end else begin
         divCnt_ff <= divCnt_ff + 4'h1;
      end
   end
   assign halfTick = state_ff != ST_IDLE && divCnt_ff == SCLK_HALF - 4'h1;

   // ==========================================
   // Link sequencer
   always_ff @(posedge refClk) begin
      if (reset) begin
         state_ff <= ST_IDLE;
         link.conversionStart <= 1'b1;
         link.serialClk <= 1'b0;
         link.serialIn <= 1'b1;
         txShift_ff <= '0;
         bitCnt_ff <= '0;
         rxData_ff <= '0;
      end else begin
         case (state_ff)
            ST_IDLE: begin
               if (startReq) begin
                  // Start bit 0, select, pattern, then data
                  txShift_ff <= {1'b0, pwdata[HCMD_RD_BIT], CMD_PATTERN,
                                 pwdata[7:0]};
                  link.serialIn <= 1'b0;
                  link.conversionStart <= 1'b0;
                  bitCnt_ff <= '0;
                  state_ff <= ST_LEAD;
               end
            end
            ST_LEAD: begin
               if (halfTick) begin
                  state_ff <= ST_SHIFT;
               end
            end
            ST_SHIFT: begin
               if (halfTick && !link.serialClk) begin
                  // Rising edge: device samples, host reads back
                  link.serialClk <= 1'b1;
                  bitCnt_ff <= bitCnt_ff + 5'h01;
                  rxData_ff <= {rxData_ff[6:0], sdoS};
               end else if (halfTick) begin
                  // Falling edge: next bit, MSB first
                  link.serialClk <= 1'b0;
                  txShift_ff <= {txShift_ff[14:0], 1'b1};
                  link.serialIn <= txShift_ff[14];
                  if (bitCnt_ff == CNT_DONE) begin
                     link.serialIn <= 1'b1;
                     state_ff <= ST_TAIL;
                  end
               end
            end
            ST_TAIL: begin
               if (halfTick) begin
                  link.conversionStart <= 1'b1;
                  state_ff <= ST_IDLE;
               end
            end
            default: begin
               state_ff <= ST_IDLE;
            end
         endcase
      end
   end

   // Busy and done flags; a new order clears done
   always_ff @(posedge refClk) begin
      if (reset) begin
         busy_ff <= 1'b0;
         done_ff <= 1'b0;
      end else if (startReq) begin
         busy_ff <= 1'b1;
         done_ff <= 1'b0;
      end else if (state_ff == ST_TAIL && halfTick) begin
         busy_ff <= 1'b0;
         done_ff <= 1'b1;
      end
   end
endmodule : acr_host
`default_nettype wire

// ---- verification/acr_link_monitor.sv ----
/*
 Checker for the serial link joining the host end to the device end.
 Assumes it is instantiated beside that link, fed with its signals.
*/
`default_nettype none
module acr_link_monitor
   import acr_pkg::*;
(
   input wire logic refClk,
   input wire logic reset,
   input wire logic conversionStart,
   input wire logic serialClk,
   input wire logic serialIn,
   input wire logic serialOut,
   input wire logic serialOutOeN
);
   // ==========================================
   // Frame bookkeeping
   logic sclkQ_ff;      // Serial clock one cycle back
   logic [4:0] cnt_ff;  // Rising edges seen in frame
   logic rdFrame_ff;    // Frame is a read
   logic sclkRise;      // Serial clock rose
   assign sclkRise = serialClk & ~sclkQ_ff;
   // Delay serial clock
   always_ff @(posedge refClk) begin
      sclkQ_ff <= serialClk;
   end
   // Count rising edges inside frame
   always_ff @(posedge refClk) begin
      if (reset || conversionStart) begin
         cnt_ff <= 5'h00;
      end else if (sclkRise) begin
         cnt_ff <= cnt_ff + 5'h01;
      end
   end
   // Capture select bit of the command
   always_ff @(posedge refClk) begin
      if (reset || conversionStart) begin
         rdFrame_ff <= 1'b0;
      end else if (sclkRise && cnt_ff == 5'h01) begin
         rdFrame_ff <= serialIn;
      end
   end
   // ==========================================
   // Assertions
   default clocking cb @(posedge refClk); endclocking
   default disable iff (reset);
   idle_clock_low_a: assert property (conversionStart |-> !serialClk)
      else $error("serial clock high outside frame");
   output_floats_a: assert property (conversionStart [*6] |-> serialOutOeN)
      else $error("data out driven outside frame");
   drive_start_a: assert property ($fell(serialOutOeN) |-> rdFrame_ff && cnt_ff == 5'h08)
      else $error("data out driven at wrong point");
   read_drives_a: assert property (sclkRise && rdFrame_ff && cnt_ff >= 5'h08 |-> !serialOutOeN)
      else $error("read data not driven");
   reserved_zero_a: assert property (sclkRise && rdFrame_ff && cnt_ff inside {5'h08, 5'h09, 5'h0A}
      |-> !serialOut)
      else $error("reserved bit read as one");
   shift_on_fall_a: assert property (serialClk [*5] ##0 !serialOutOeN |-> $stable(serialOut))
      else $error("data out changed while clock high");
   first_bit_zero_a: assert property (sclkRise && cnt_ff == 5'h00 |-> !serialIn)
      else $error("command start bit not zero");
   cmd_pattern_a: assert property (sclkRise && cnt_ff >= 5'h02 && cnt_ff <= 5'h07
      |-> serialIn == CMD_PATTERN[7 - cnt_ff])
      else $error("command pattern bit wrong");
   frame_length_a: assert property ($rose(conversionStart) |-> cnt_ff == CNT_DONE)
      else $error("frame not sixteen bits");
   clock_level_a: assert property ($rose(serialClk) |-> serialClk [*4])
      else $error("serial clock high too short");
endmodule : acr_link_monitor
`default_nettype wire

// ---- verification/tb.sv ----
/*
 Testbench: host and device ends joined by one link, driven over APB;
 a second device on a second link gets faulty frames from the bench.
 Assumes the package, the link interface and both ends are compiled.
*/
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import acr_pkg::*;
   // ==========================================
   // Signals
   logic refClk, reset, psel, penable, pwrite, pready, pslverr, overvoltageIn;
   logic [31:0] paddr, pwdata, prdata, r, seed;
   wire logic [4:0] dev1Out, dev2Out;  // Status, span, high-Z, turbo, flag
   logic [7:0] got, v;
   logic e;
   int n_errors = 0;
   int n_compared = 0;
   int cycles = 0;
   int cfgM;                      // Register model
   logic [15:0] fr [4] = '{16'h941E, 16'h151E, 16'h141E, 16'h14FF};
   int nb [4] = '{16, 16, 12, 16};
   acr_link_if link1 ();
   acr_link_if link2 ();
   acr_host i_acr_host (.refClk(refClk), .reset(reset), .link(link1), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr));
   acr_device i_acr_device (.refClk(refClk), .reset(reset), .link(link1),
      .overvoltageIn(overvoltageIn), .statusBitsEn(dev1Out[4]), .spanCompressEn(dev1Out[3]),
      .highZEn(dev1Out[2]), .turboEn(dev1Out[1]), .overvoltageIndicatorN(dev1Out[0]));
   acr_device i_acr_device2 (.refClk(refClk), .reset(reset), .link(link2),
      .overvoltageIn(1'b0), .statusBitsEn(dev2Out[4]), .spanCompressEn(dev2Out[3]),
      .highZEn(dev2Out[2]), .turboEn(dev2Out[1]), .overvoltageIndicatorN(dev2Out[0]));
   acr_link_monitor i_acr_link_monitor (.refClk(refClk), .reset(reset),
      .conversionStart(link1.conversionStart), .serialClk(link1.serialClk),
      .serialIn(link1.serialIn), .serialOut(link1.serialOut),
      .serialOutOeN(link1.serialOutOeN));
   // ==========================================
   // Clock and timeout
   initial begin
      refClk = 1'b0;
      forever #12.5 refClk = ~refClk;
   end
   // Cut a hang short
   always @(posedge refClk) begin
      cycles++;
      if (cycles == 40000) begin
         n_errors++;
         report_and_stop();
      end
   end
   // ==========================================
   // Tasks
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : xs
   // Compare one register image
   task check(input string what, input logic [7:0] exp, input logic [7:0] seen);
      n_compared++;
      if (seen !== exp) begin
         n_errors++;
         $display("unexpected %s: expected %h, seen %h", what, exp, seen);
      end
   endtask : check
   // One APB transfer, waits for pready
   task apb(input logic wr, input logic [31:0] a, input logic [31:0] d,
            output logic [31:0] rd, output logic err);
      @(posedge refClk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge refClk);
      penable <= 1'b1;
      // Ends when pready is high; only the bench timeout ends a hang
      do begin
         @(posedge refClk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   // Order one instruction and poll until done
   task xfer(input logic rd, input logic [7:0] d, output logic [7:0] q);
      apb(1'b1, HOST_CMD_ADDR, {23'h0, rd, d}, r, e);
      // Poll until finished; a hang ends at the bench timeout
      do begin
         apb(1'b0, HOST_STAT_ADDR, 32'h0, r, e);
      end while (r[HSTAT_BUSY_BIT] !== 1'b0 || r[HSTAT_DONE_BIT] !== 1'b1);
      q = r[HSTAT_DATA_LSB +: 8];
   endtask : xfer
   // Bench-made frame on the second link, 200 ns clock
   task frame2(input logic [15:0] bits, input int n);
      logic [15:0] s;
      s = bits;
      @(posedge refClk);
      link2.conversionStart <= 1'b0;
      link2.serialIn <= s[15];
      for (int i = 0; i < n; i++) begin
         repeat (4) @(posedge refClk);
         link2.serialClk <= 1'b1;
         repeat (4) @(posedge refClk);
         link2.serialClk <= 1'b0;
         s = s << 1;
         link2.serialIn <= s[15];
      end
      repeat (4) @(posedge refClk);
      link2.conversionStart <= 1'b1;
      link2.serialIn <= 1'b1;
      repeat (8) @(posedge refClk);
   endtask : frame2
   // Verdict and end of run
   task report_and_stop();
      if (n_errors == 0 && n_compared > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : report_and_stop
   // ==========================================
   // Main sequence
   initial begin
      reset = 1'b1;
      {psel, penable, pwrite, overvoltageIn} = 4'h0;
      paddr = 32'h0;
      pwdata = 32'h0;
      seed = 32'h0000_0EA2;
      link2.conversionStart = 1'b1;
      link2.serialClk = 1'b0;
      link2.serialIn = 1'b1;
      repeat (12) @(posedge refClk);
      reset <= 1'b0;
      repeat (4) @(posedge refClk);
      cfgM = 'h01;
      check("reset image", cfgM, {3'h0, dev1Out});
      xfer(1'b1, 8'h00, got);
      check("read after reset", cfgM, got);
      apb(1'b0, 32'h0000_0008, 32'h0, r, e);
      check("unmapped error", 8'h01, {7'h0, e});
      check("unmapped data", 8'h00, r[7:0]);
      // Writes then reads, corner values then random
      for (int i = 0; i < 8; i++) begin
         r = xs();
         v = (i == 0) ? 8'hFF : (i == 1) ? 8'h00 : r[7:0];
         xfer(1'b0, v, got);
         cfgM = (cfgM & 1) | (v & 30);
         check("outputs after write", cfgM, {3'h0, dev1Out});
         xfer(1'b1, 8'h00, got);
         check("read back", cfgM, got);
      end
      // Overvoltage event, sticky flag
      overvoltageIn <= 1'b1;
      repeat (6) @(posedge refClk);
      cfgM = cfgM & 30;
      check("flag on event", cfgM, {3'h0, dev1Out});
      xfer(1'b0, 8'hFF, got);
      cfgM = (cfgM & 1) | 30;
      check("write keeps flag", cfgM, {3'h0, dev1Out});
      xfer(1'b1, 8'h00, got);
      check("read during event", cfgM, got);
      check("flag after read", cfgM, {3'h0, dev1Out});
      overvoltageIn <= 1'b0;
      repeat (6) @(posedge refClk);
      check("flag sticky", cfgM, {3'h0, dev1Out});
      xfer(1'b1, 8'h00, got);
      check("read after event", cfgM, got);
      cfgM = cfgM | 1;
      check("flag cleared", cfgM, {3'h0, dev1Out});
      xfer(1'b1, 8'h00, got);
      check("read after clear", cfgM, got);
      // Faulty frames, then one good write, on the second device
      for (int i = 0; i < 4; i++) begin
         frame2(fr[i], nb[i]);
         check("second device", (i == 3) ? 8'h1F : 8'h01, {3'h0, dev2Out});
      end
      report_and_stop();
   end
endmodule : tb
`default_nettype wire
